// >>> verilog/cbs_pkg.sv
/*
 * Package for the bus-cycle sequencer: cycle type codes, slow wait limits,
 * branch sequence lengths and widths shared by the sequencer files.
 * Assumes a single core clock domain and no software-visible registers.
 */
package cbs_pkg;

	// Cycle types issued by the core, one per execution step
	typedef enum logic [4:0] {
		CBS_CYC_FREE,       // f
		CBS_CYC_PAGE_RD,    // internal page register read
		CBS_CYC_IND_PTR,    // 16-bit indirect pointer read
		CBS_CYC_IND_PAGE,   // 8-bit indirect page value read
		CBS_CYC_PAGE_WR,    // internal page register write
		CBS_CYC_OPT,        // optional cycle
		CBS_CYC_PROG,       // program word fetch
		CBS_CYC_RD8,
		CBS_CYC_RD16,
		CBS_CYC_STK8,
		CBS_CYC_STK16,
		CBS_CYC_WR8,
		CBS_CYC_WR16,
		CBS_CYC_UNSTK8,
		CBS_CYC_UNSTK16,
		CBS_CYC_VECTOR,
		CBS_CYC_COND_RD8,
		CBS_CYC_COND_RD16,
		CBS_CYC_COND_WR8
	} cbs_cycle_t;

	// Width of the extra-cycle count
	localparam int CBS_CNT_W = 4;
	localparam logic [CBS_CNT_W-1:0] CBS_CNT_ZERO = 4'h0;
	localparam logic [CBS_CNT_W-1:0] CBS_CNT_ONE = 4'h1;

	// Branch sequence lengths
	localparam logic [2:0] CBS_SBR_TAKEN_LEN = 3'h3;
	localparam logic [2:0] CBS_SBR_NOT_LEN = 3'h1;
	localparam logic [2:0] CBS_LBR_TAKEN_LEN = 3'h4;
	localparam logic [2:0] CBS_LBR_NOT_LEN = 3'h3;
	localparam logic [2:0] CBS_LEN_ZERO = 3'h0;

	// Default slow chip-select extra bus clocks
	localparam int CBS_SLOW_WAIT_DEF = 1;
	// Largest slow wait accepted; with split and misalign it stays inside the extra-cycle count
	localparam int CBS_SLOW_WAIT_MAX = 4;

endpackage

// >>> verilog/cbs_stretch_calc.sv
/*
 * Combinational stretch calculator: turns one resolved access into the
 * number of extra bus clocks it needs.
 * Assumes the caller has already resolved optional and conditional cycles.
 */
`timescale 1ns/1ps

module cbs_stretch_calc
	import cbs_pkg::*;
#(
	parameter int SLOW_WAIT = CBS_SLOW_WAIT_DEF
) (
	input wire cbs_cycle_t i_cycle,
	input wire logic i_is_free,
	input wire logic i_external,
	input wire logic i_narrow_bus,
	input wire logic i_slow_cs,
	input wire logic i_misaligned,
	input wire logic i_misalign_ok,
	output logic [CBS_CNT_W-1:0] o_extra,
	output logic o_on_bus
);

	// Refuse slow wait lengths below zero or above CBS_SLOW_WAIT_MAX
	if (SLOW_WAIT < 0 || SLOW_WAIT > CBS_SLOW_WAIT_MAX) begin : g_bad_wait
		$error("cbs_stretch_calc: SLOW_WAIT out of range");
	end

	localparam logic [CBS_CNT_W-1:0] SLOW_CNT = CBS_CNT_W'(SLOW_WAIT);

	logic wide;
	logic split_ok;
	logic align_ok;
	logic slow_ok;

	// Classify which stretch causes apply to this cycle type
	always_comb begin
		wide = 1'b0;
		split_ok = 1'b0;
		align_ok = 1'b0;
		slow_ok = 1'b1;
		o_on_bus = 1'b1;
		unique case (i_cycle)
			CBS_CYC_FREE, CBS_CYC_OPT, CBS_CYC_PAGE_RD, CBS_CYC_PAGE_WR: begin
				slow_ok = 1'b0;
				o_on_bus = 1'b0;
			end
			CBS_CYC_IND_PTR, CBS_CYC_RD16, CBS_CYC_WR16, CBS_CYC_COND_RD16: begin
				wide = 1'b1;
				split_ok = 1'b1;
				align_ok = 1'b1;
			end
			CBS_CYC_STK16, CBS_CYC_UNSTK16: begin
				wide = 1'b1;
				split_ok = 1'b1;
				align_ok = 1'b1;
			end
			CBS_CYC_PROG, CBS_CYC_VECTOR: begin
				wide = 1'b1;
				split_ok = 1'b1;
			end
			default: begin
				wide = 1'b0;
			end
		endcase
		if (i_is_free) begin
			slow_ok = 1'b0;
			o_on_bus = 1'b0;
			split_ok = 1'b0;
			align_ok = 1'b0;
		end
	end

	// Sum the extra bus clocks
	always_comb begin
		o_extra = CBS_CNT_ZERO;
		if (split_ok && wide && i_external && i_narrow_bus) begin
			o_extra = o_extra + CBS_CNT_ONE;
		end
		if (align_ok && i_misaligned && !i_misalign_ok) begin
			o_extra = o_extra + CBS_CNT_ONE;
		end
		if (slow_ok && i_slow_cs) begin
			o_extra = o_extra + SLOW_CNT;
		end
	end

endmodule

// >>> verilog/cbs_sequencer.sv
/*
 * Bus-cycle sequencer: takes one cycle request per core step, resolves
 * optional and conditional cycles, stretches slow or split accesses by
 * holding the core clock enable low, and reports branch sequence lengths.
 * Assumes address decode (external, slow chip-select, misaligned) is
 * supplied by the memory map logic on the same clock.
 */
`timescale 1ns/1ps

// Behaviour
// - One step per core cycle; uppercase means wide
// - Core clock enable held low while stretching
// - Free cycle never uses buses, one clock
// - Page register accesses internal, never stretched
// - Indirect pointer wide; split, slow, misalign stretch
// - Indirect page value stretched only by slow
// - Optional becomes fetch for odd misaligned instruction
// - Prebyte optional fetch if misaligned, else free
// - Second optional cycle opposite of prebyte's
// - Free optional never stretched; fetch optional stretches
// - Program fetch aligned wide, split and slow
// - Byte data/stack cycles stretched only by slow
// - Wide data split, slow and misalign stretch
// - Wide stack split; on-chip RAM never misaligned
// - Vectors aligned wide, split and slow stretch
// - Conditional cycles real access or free
// - Short branch three taken, one not
// - Long branch four taken, three not
module cbs_sequencer
	import cbs_pkg::*;
#(
	parameter int SLOW_WAIT = CBS_SLOW_WAIT_DEF
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_step_valid,
	input wire cbs_cycle_t i_cycle,
	input wire logic i_odd_len,
	input wire logic i_first_misaligned,
	input wire logic i_prebyte,
	input wire logic i_cond_active,
	input wire logic i_external,
	input wire logic i_narrow_bus,
	input wire logic i_slow_cs,
	input wire logic i_misaligned,
	input wire logic i_internal_ram,
	input wire logic i_short_branch,
	input wire logic i_long_branch,
	input wire logic i_branch_taken,
	output logic o_core_clk_en,
	output logic o_stretch_req,
	output logic o_bus_active,
	output logic o_bus_free,
	output logic o_fetch,
	output logic [2:0] o_branch_len,
	output cbs_cycle_t o_cycle
);

	// ****************************************
	// Optional cycle resolution
	// ****************************************

	logic prebyte_fetch_reg;
	logic prebyte_seen_reg;
	logic opt_is_fetch;
	logic is_free;
	logic [CBS_CNT_W-1:0] extra;
	logic on_bus;
	logic [CBS_CNT_W-1:0] stretch_cnt_reg;
	logic busy;
	logic accept;

	assign busy = (stretch_cnt_reg != CBS_CNT_ZERO);
	assign accept = i_step_valid && !busy;

	// Decide what the optional cycle turns into
	always_comb begin
		if (i_prebyte) begin
			opt_is_fetch = i_first_misaligned;
		end else if (prebyte_seen_reg) begin
			opt_is_fetch = !prebyte_fetch_reg && i_odd_len;
		end else begin
			opt_is_fetch = i_odd_len && i_first_misaligned;
		end
	end

	// Remember the prebyte's choice until the instruction's next optional cycle
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			prebyte_seen_reg <= 1'b0;
			prebyte_fetch_reg <= 1'b0;
		end else if (i_step_valid && !busy && i_cycle == CBS_CYC_OPT) begin
			prebyte_seen_reg <= i_prebyte;
			prebyte_fetch_reg <= i_prebyte && opt_is_fetch;
		end
	end

	// Free-acting cycles: plain free, unused optional, idle conditional
	always_comb begin
		unique case (i_cycle)
			CBS_CYC_FREE: is_free = 1'b1;
			CBS_CYC_OPT: is_free = !opt_is_fetch;
			CBS_CYC_COND_RD8, CBS_CYC_COND_RD16, CBS_CYC_COND_WR8: begin
				is_free = !i_cond_active;
			end
			default: is_free = 1'b0;
		endcase
	end

	// ****************************************
	// Stretch calculation and counter
	// ****************************************

	cbs_stretch_calc #(
		.SLOW_WAIT(SLOW_WAIT)
	) u_calc (
		.i_cycle(opt_is_fetch && i_cycle == CBS_CYC_OPT ? CBS_CYC_PROG : i_cycle),
		.i_is_free(is_free),
		.i_external(i_external),
		.i_narrow_bus(i_narrow_bus),
		.i_slow_cs(i_slow_cs),
		.i_misaligned(i_misaligned),
		.i_misalign_ok(i_internal_ram),
		.o_extra(extra),
		.o_on_bus(on_bus)
	);

	// Count down one per extra bus clock
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stretch_cnt_reg <= CBS_CNT_ZERO;
		end else if (busy) begin
			stretch_cnt_reg <= stretch_cnt_reg - CBS_CNT_ONE;
		end else if (i_step_valid) begin
			stretch_cnt_reg <= extra;
		end
	end

	// Core clock frozen during stretch, so each step stays one core cycle
	assign o_core_clk_en = !busy;
	assign o_stretch_req = busy;

	// ****************************************
	// Registered cycle outputs
	// ****************************************

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_bus_active <= 1'b0;
			o_bus_free <= 1'b1;
			o_fetch <= 1'b0;
			o_cycle <= CBS_CYC_FREE;
		end else if (!busy) begin
			o_bus_active <= i_step_valid && on_bus;
			o_bus_free <= !(i_step_valid && on_bus);
			o_fetch <= i_step_valid && (i_cycle == CBS_CYC_PROG || 
				(i_cycle == CBS_CYC_OPT && opt_is_fetch));
			o_cycle <= i_step_valid ? i_cycle : CBS_CYC_FREE;
		end
	end

	// ****************************************
	// Branch sequence length
	// ****************************************

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_branch_len <= CBS_LEN_ZERO;
		end else if (i_step_valid && !busy) begin
			if (i_short_branch) begin
				o_branch_len <= i_branch_taken ? CBS_SBR_TAKEN_LEN : CBS_SBR_NOT_LEN;
			end else if (i_long_branch) begin
				o_branch_len <= i_branch_taken ? CBS_LBR_TAKEN_LEN : CBS_LBR_NOT_LEN;
			end else begin
				o_branch_len <= CBS_LEN_ZERO;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************

	property p_clk_low_when_busy;
		@(posedge i_clk) disable iff (i_reset)
		(accept && extra != CBS_CNT_ZERO) |=> !o_core_clk_en && o_stretch_req;
	endproperty
	a_clk_low_when_busy: assert property (p_clk_low_when_busy)
		else $error("core clock enabled during stretch");

	property p_free_one_clock;
		@(posedge i_clk) disable iff (i_reset)
		(i_step_valid && !busy && i_cycle == CBS_CYC_FREE) |=> o_core_clk_en && !o_bus_active;
	endproperty
	a_free_one_clock: assert property (p_free_one_clock)
		else $error("free cycle stretched or on bus");

	property p_page_never_stretched;
		@(posedge i_clk) disable iff (i_reset)
		(i_step_valid && !busy && (i_cycle == CBS_CYC_PAGE_RD || i_cycle == CBS_CYC_PAGE_WR))
			|=> o_core_clk_en;
	endproperty
	a_page_never_stretched: assert property (p_page_never_stretched)
		else $error("page register cycle stretched");

	property p_narrow_split;
		@(posedge i_clk) disable iff (i_reset)
		(i_step_valid && !busy && i_cycle == CBS_CYC_PROG && i_external && i_narrow_bus
			&& !i_slow_cs) |=> !o_core_clk_en ##1 o_core_clk_en;
	endproperty
	a_narrow_split: assert property (p_narrow_split)
		else $error("external narrow fetch not split in two");

	property p_byte_no_width_stretch;
		@(posedge i_clk) disable iff (i_reset)
		(i_step_valid && !busy && i_cycle == CBS_CYC_RD8 && !i_slow_cs) |=> o_core_clk_en;
	endproperty
	a_byte_no_width_stretch: assert property (p_byte_no_width_stretch)
		else $error("byte access stretched without slow select");

	property p_opt_free;
		@(posedge i_clk) disable iff (i_reset)
		(i_step_valid && !busy && i_cycle == CBS_CYC_OPT && !opt_is_fetch) |=> o_core_clk_en;
	endproperty
	a_opt_free: assert property (p_opt_free)
		else $error("free optional cycle stretched");

	property p_stack_ram_no_misalign;
		@(posedge i_clk) disable iff (i_reset)
		(i_step_valid && !busy && i_cycle == CBS_CYC_STK16 && i_internal_ram && !i_external
			&& !i_slow_cs) |=> o_core_clk_en;
	endproperty
	a_stack_ram_no_misalign: assert property (p_stack_ram_no_misalign)
		else $error("on-chip stack access stretched");

	property p_short_taken;
		@(posedge i_clk) disable iff (i_reset)
		(i_step_valid && !busy && i_short_branch && i_branch_taken)
			|=> o_branch_len == CBS_SBR_TAKEN_LEN;
	endproperty
	a_short_taken: assert property (p_short_taken)
		else $error("short branch taken length wrong");

	property p_long_not;
		@(posedge i_clk) disable iff (i_reset)
		(i_step_valid && !busy && i_long_branch && !i_branch_taken)
			|=> o_branch_len == CBS_LBR_NOT_LEN;
	endproperty
	a_long_not: assert property (p_long_not)
		else $error("long branch not-taken length wrong");

	property p_hold_while_frozen;
		@(posedge i_clk) disable iff (i_reset)
		!o_core_clk_en |=> $stable(o_cycle) && $stable(o_fetch) && $stable(o_branch_len);
	endproperty
	a_hold_while_frozen: assert property (p_hold_while_frozen)
		else $error("registered outputs moved during stretch");

	property p_prebyte_fetch;
		@(posedge i_clk) disable iff (i_reset)
		(accept && i_cycle == CBS_CYC_OPT && i_prebyte && i_first_misaligned)
			|=> o_fetch && o_bus_active;
	endproperty
	a_prebyte_fetch: assert property (p_prebyte_fetch)
		else $error("misaligned prebyte optional cycle not a fetch");

	property p_prebyte_free;
		@(posedge i_clk) disable iff (i_reset)
		(accept && i_cycle == CBS_CYC_OPT && i_prebyte && !i_first_misaligned)
			|=> !o_fetch && !o_bus_active && o_core_clk_en;
	endproperty
	a_prebyte_free: assert property (p_prebyte_free)
		else $error("aligned prebyte optional cycle not free");

	property p_second_opt;
		@(posedge i_clk) disable iff (i_reset)
		(accept && i_cycle == CBS_CYC_OPT && !i_prebyte && prebyte_seen_reg && i_odd_len)
			|=> o_fetch == !$past(prebyte_fetch_reg);
	endproperty
	a_second_opt: assert property (p_second_opt)
		else $error("second optional cycle not opposite of prebyte");

	property p_vector_split;
		@(posedge i_clk) disable iff (i_reset)
		(accept && i_cycle == CBS_CYC_VECTOR && i_external && i_narrow_bus && !i_slow_cs)
			|=> !o_core_clk_en ##1 o_core_clk_en;
	endproperty
	a_vector_split: assert property (p_vector_split)
		else $error("external narrow vector not split in two");

	property p_ind_page_slow;
		@(posedge i_clk) disable iff (i_reset)
		(accept && i_cycle == CBS_CYC_IND_PAGE && !i_slow_cs) |=> o_core_clk_en;
	endproperty
	a_ind_page_slow: assert property (p_ind_page_slow)
		else $error("indirect page value stretched without slow select");

	property p_short_not;
		@(posedge i_clk) disable iff (i_reset)
		(accept && i_short_branch && !i_branch_taken) |=> o_branch_len == CBS_SBR_NOT_LEN;
	endproperty
	a_short_not: assert property (p_short_not)
		else $error("short branch not-taken length wrong");

	property p_long_taken;
		@(posedge i_clk) disable iff (i_reset)
		(accept && !i_short_branch && i_long_branch && i_branch_taken)
			|=> o_branch_len == CBS_LBR_TAKEN_LEN;
	endproperty
	a_long_taken: assert property (p_long_taken)
		else $error("long branch taken length wrong");

	property p_cond_idle;
		@(posedge i_clk) disable iff (i_reset)
		(accept && (i_cycle == CBS_CYC_COND_RD8 || i_cycle == CBS_CYC_COND_RD16
			|| i_cycle == CBS_CYC_COND_WR8) && !i_cond_active) |=> o_core_clk_en && !o_bus_active;
	endproperty
	a_cond_idle: assert property (p_cond_idle)
		else $error("idle conditional cycle used bus or stretched");

	c_split: cover property (@(posedge i_clk) disable iff (i_reset) busy ##1 !busy);
	c_opt_fetch: cover property (@(posedge i_clk) disable iff (i_reset)
		i_step_valid && i_cycle == CBS_CYC_OPT && opt_is_fetch);
	c_long_taken: cover property (@(posedge i_clk) disable iff (i_reset)
		i_step_valid && i_long_branch && i_branch_taken);
	c_second_opt: cover property (@(posedge i_clk) disable iff (i_reset)
		accept && i_cycle == CBS_CYC_OPT && prebyte_seen_reg && !i_prebyte);

endmodule

// >>> test/cbs_mem_model.sv
/*
 * Memory map model beside the sequencer: region code and address flags
 * in, decode levels out. Assumes the bench changes it only between steps.
 */
`timescale 1ns/1ps

module cbs_mem_model (
	input wire logic [1:0] i_region,
	input wire logic i_slow_sel,
	input wire logic i_odd,
	output logic o_external,
	output logic o_narrow_bus,
	output logic o_slow_cs,
	output logic o_misaligned,
	output logic o_internal_ram
);
	// ****************
	// Region decode
	// ****************
	// Region 0 on-chip RAM, 1 on-chip flash, 2 external wide, 3 external narrow
	assign o_external = i_region[1];
	assign o_narrow_bus = (i_region == 2'h3);
	assign o_slow_cs = i_region[1] & i_slow_sel; // Slow selects cover external space
	assign o_misaligned = i_odd;
	assign o_internal_ram = (i_region == 2'h0); // RAM takes odd words in one go
endmodule

// >>> test/tb.sv
/*
 * Self-checking bench for the bus-cycle sequencer, one task per scenario.
 * Assumes the memory map model drives the address decode levels.
 */
`timescale 1ns/1ps

module tb;
	import cbs_pkg::*;
	localparam int SW = 2;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic stp = 1'b0, odd_len = 1'b0, fmis = 1'b0, pre = 1'b0, cact = 1'b0;
	logic sbr = 1'b0, lbr = 1'b0, tk = 1'b0, slow_sel = 1'b0, odd = 1'b0;
	logic [1:0] region = 2'h0;
	cbs_cycle_t cyc = CBS_CYC_FREE;
	logic ext, nar, slw, mis, iram, clk_en, sreq, bact, bfree, fch;
	logic [2:0] blen;
	cbs_cycle_t ocyc;
	int n_mismatch = 0, cmp_count = 0, cycles = 0;

	// Clock and hang guard
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			close_out();
		end
	end

	cbs_mem_model MEM (.i_region(region), .i_slow_sel(slow_sel), .i_odd(odd),
		.o_external(ext), .o_narrow_bus(nar), .o_slow_cs(slw), .o_misaligned(mis),
		.o_internal_ram(iram));
	cbs_sequencer #(.SLOW_WAIT(SW)) DUT (.i_clk(i_clk), .i_reset(i_reset),
		.i_step_valid(stp), .i_cycle(cyc), .i_odd_len(odd_len),
		.i_first_misaligned(fmis), .i_prebyte(pre), .i_cond_active(cact),
		.i_external(ext), .i_narrow_bus(nar), .i_slow_cs(slw), .i_misaligned(mis),
		.i_internal_ram(iram), .i_short_branch(sbr), .i_long_branch(lbr),
		.i_branch_taken(tk), .o_core_clk_en(clk_en), .o_stretch_req(sreq),
		.o_bus_active(bact), .o_bus_free(bfree), .o_fetch(fch), .o_branch_len(blen),
		.o_cycle(ocyc));

	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	// One step; x on f or b skips that check; counts frozen core clocks
	task automatic run(input cbs_cycle_t c, input int n, input logic f, input logic b);
		int k;
		cyc = c;
		stp = 1'b1;
		@(negedge i_clk);
		k = 0;
		chk(ocyc === c, "cycle type");
		if (f !== 1'bx) chk(fch === f, "fetch flag");
		if (b !== 1'bx) chk(bact === b && bfree === !b, "bus use");
		while (clk_en !== 1'b1 && k < 20) begin
			chk(sreq === 1'b1, "stretch request");
			k++;
			@(negedge i_clk);
		end
		chk(k == n, "frozen clock count");
	endtask

	task automatic done(input string m);
		stp = 1'b0;
		@(negedge i_clk);
		$display("test %s finished", m);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		chk(clk_en === 1'b1 && bfree === 1'b1 && bact === 1'b0, "reset levels");
		chk(blen === CBS_LEN_ZERO && ocyc === CBS_CYC_FREE, "reset state");
		done("reset");
	endtask

	task automatic t_free_page();
		region = 2'h3;
		slow_sel = 1'b1;
		odd = 1'b1;
		run(CBS_CYC_FREE, 0, 1'b0, 1'b0);
		run(CBS_CYC_PAGE_RD, 0, 1'b0, 1'b0);
		run(CBS_CYC_PAGE_WR, 0, 1'b0, 1'b0);
		done("free_page");
	endtask

	task automatic t_indirect();
		run(CBS_CYC_IND_PTR, 2 + SW, 1'b0, 1'b1);
		run(CBS_CYC_IND_PAGE, SW, 1'b0, 1'b1);
		slow_sel = 1'b0;
		run(CBS_CYC_IND_PAGE, 0, 1'b0, 1'b1);
		region = 2'h0;
		run(CBS_CYC_IND_PTR, 0, 1'b0, 1'b1);
		done("indirect");
	endtask

	// Reset in the middle of a stretch clears it
	task automatic t_mid_reset();
		region = 2'h3;
		slow_sel = 1'b1;
		odd = 1'b1;
		cyc = CBS_CYC_IND_PTR;
		stp = 1'b1;
		@(negedge i_clk);
		chk(clk_en === 1'b0, "stretch before reset");
		stp = 1'b0;
		i_reset = 1'b1;
		repeat (2) @(negedge i_clk);
		i_reset = 1'b0;
		chk(clk_en === 1'b1 && sreq === 1'b0 && bfree === 1'b1, "mid-run reset levels");
		chk(ocyc === CBS_CYC_FREE && fch === 1'b0 && blen === CBS_LEN_ZERO, "mid-run state");
		done("mid_reset");
	endtask

	task automatic t_opt();
		region = 2'h3;
		slow_sel = 1'b1;
		odd_len = 1'b1;
		fmis = 1'b1;
		run(CBS_CYC_OPT, 1 + SW, 1'b1, 1'b1);
		fmis = 1'b0;
		run(CBS_CYC_OPT, 0, 1'b0, 1'b0);
		slow_sel = 1'b0;
		pre = 1'b1;
		fmis = 1'b1;
		run(CBS_CYC_OPT, 1, 1'b1, 1'b1);
		pre = 1'b0;
		run(CBS_CYC_OPT, 0, 1'b0, 1'b0);
		pre = 1'b1;
		fmis = 1'b0;
		run(CBS_CYC_OPT, 0, 1'b0, 1'b0);
		pre = 1'b0;
		run(CBS_CYC_OPT, 1, 1'b1, 1'b1);
		odd_len = 1'b0;
		done("optional");
	endtask

	task automatic t_prog_vec();
		odd = 1'b1;
		run(CBS_CYC_PROG, 1, 1'b1, 1'b1);
		region = 2'h2;
		slow_sel = 1'b1;
		run(CBS_CYC_PROG, SW, 1'b1, 1'b1);
		region = 2'h3;
		run(CBS_CYC_VECTOR, 1 + SW, 1'b0, 1'b1);
		region = 2'h1;
		run(CBS_CYC_VECTOR, 0, 1'b0, 1'b1);
		done("prog_vector");
	endtask

	task automatic t_byte();
		cbs_cycle_t bl [6] = '{CBS_CYC_RD8, CBS_CYC_WR8, CBS_CYC_STK8, CBS_CYC_UNSTK8,
			CBS_CYC_COND_RD8, CBS_CYC_COND_WR8};
		region = 2'h3;
		cact = 1'b1;
		for (int i = 0; i < 12; i++) begin
			slow_sel = (i >= 6);
			run(bl[i % 6], (i >= 6) ? SW : 0, 1'b0, 1'b1);
		end
		done("byte_data");
	endtask

	task automatic t_wide();
		run(CBS_CYC_RD16, 2 + SW, 1'b0, 1'b1);
		run(CBS_CYC_WR16, 2 + SW, 1'b0, 1'b1);
		region = 2'h2;
		slow_sel = 1'b0;
		run(CBS_CYC_RD16, 1, 1'b0, 1'b1);
		region = 2'h0;
		run(CBS_CYC_STK16, 0, 1'b0, 1'b1);
		run(CBS_CYC_UNSTK16, 0, 1'b0, 1'b1);
		region = 2'h3;
		odd = 1'b0;
		run(CBS_CYC_STK16, 1, 1'b0, 1'b1);
		run(CBS_CYC_UNSTK16, 1, 1'b0, 1'b1);
		done("wide_data");
	endtask

	task automatic t_cond();
		slow_sel = 1'b1;
		odd = 1'b1;
		cact = 1'b0;
		run(CBS_CYC_COND_RD16, 0, 1'b0, 1'b0);
		run(CBS_CYC_COND_WR8, 0, 1'b0, 1'b0);
		cact = 1'b1;
		run(CBS_CYC_COND_RD16, 2 + SW, 1'b0, 1'b1);
		done("conditional");
	endtask

	task automatic t_branch();
		logic [2:0] lens [4] = '{CBS_SBR_TAKEN_LEN, CBS_SBR_NOT_LEN, CBS_LBR_TAKEN_LEN,
			CBS_LBR_NOT_LEN};
		region = 2'h1;
		for (int i = 0; i < 5; i++) begin
			sbr = (i < 2);
			lbr = (i == 2 || i == 3);
			tk = (i % 2 == 0);
			run(CBS_CYC_PROG, 0, 1'b1, 1'b1);
			chk(blen === ((i < 4) ? lens[i % 4] : CBS_LEN_ZERO), "branch length");
		end
		done("branch");
	endtask

	// Main sequence
	initial begin
		repeat (12) @(negedge i_clk);
		i_reset = 1'b0;
		t_reset();
		t_free_page();
		t_indirect();
		t_mid_reset();
		t_opt();
		t_prog_vec();
		t_byte();
		t_wide();
		t_cond();
		t_branch();
		close_out();
	end
endmodule
